// >>> logic/awd_window_cmp.sv
`timescale 1ns/100ps
`default_nettype none
module awd_window_cmp (
	input wire logic [15:0] word,
	input wire logic [15:0] gt_limit,
	input wire logic [15:0] lt_limit,
	input wire logic signed_mode,
	output logic match,
	output var awd_pkg::awd_win_mode_t mode
);

	// ----------------------------------------
	// window decision
	// ----------------------------------------
	logic above_gt;
	logic below_lt;
	logic lt_over_gt;

	assign above_gt = awd_pkg::awd_greater(word, gt_limit, signed_mode); // [RULE10]
	assign below_lt = awd_pkg::awd_greater(lt_limit, word, signed_mode); // [RULE10]
	assign lt_over_gt = awd_pkg::awd_greater(lt_limit, gt_limit, signed_mode); // [RULE4]
	assign mode = lt_over_gt ? awd_pkg::AWD_WIN_INSIDE : awd_pkg::AWD_WIN_OUTSIDE; // [RULE11]
	assign match = (mode == awd_pkg::AWD_WIN_INSIDE) ? (above_gt && below_lt) // [RULE7]
		: (above_gt || below_lt); // [RULE8]

endmodule
`default_nettype wire

// >>> logic/awd_window_detector.sv
// Notes on behaviour
// [RULE1] compare every result, flag on window hit
// [RULE2] match flag readable and drives interrupt
// [RULE3] greater and less limits, high/low bytes
// [RULE4] limit contents alone choose inside/outside
// [RULE5] software writes limits in result format
// [RULE6] single-ended result unsigned, ten bits
// [RULE7] inside: above greater and below less
// [RULE8] outside: below lower or above upper
// [RULE9] differential result ten-bit two's complement
// [RULE10] differential compares are signed
// [RULE11] less over greater means inside window
// [RULE12] flag sticky until software writes zero
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "awd_defines.svh"
module awd_window_detector (
	input wire logic clk,
	input wire logic arst_n,
	input wire awd_pkg::awd_bus_req_t bus,
	output logic [7:0] rd_data,
	input wire awd_pkg::awd_result_t conv,
	input wire logic conversion_busy,
	output logic converter_enable,
	output logic tracking_mode_select,
	output logic [2:0] start_source_select,
	output logic window_match_flag,
	output logic irq
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic [1:0] cfg_q;
	logic [7:0] gt_hi_q;
	logic [7:0] gt_lo_q;
	logic [7:0] lt_hi_q;
	logic [7:0] lt_lo_q;
	logic [15:0] res_q;
	logic [1:0] stat_q;
	logic [1:0] stat_d;
	logic [1:0] mask_q;
	logic [7:0] rd_data_q;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	logic wr_ctrl;
	logic wr_cfg;
	logic wr_gt_hi;
	logic wr_gt_lo;
	logic wr_lt_hi;
	logic wr_lt_lo;
	logic wr_stat;
	logic wr_mask;

	assign wr_ctrl = bus.wr && (bus.addr == `AWD_CTRL_ADDR);
	assign wr_cfg = bus.wr && (bus.addr == `AWD_CFG_ADDR);
	assign wr_gt_hi = bus.wr && (bus.addr == `AWD_GT_HI_ADDR);
	assign wr_gt_lo = bus.wr && (bus.addr == `AWD_GT_LO_ADDR);
	assign wr_lt_hi = bus.wr && (bus.addr == `AWD_LT_HI_ADDR);
	assign wr_lt_lo = bus.wr && (bus.addr == `AWD_LT_LO_ADDR);
	assign wr_stat = bus.wr && (bus.addr == `AWD_INT_STAT_ADDR);
	assign wr_mask = bus.wr && (bus.addr == `AWD_INT_MASK_ADDR);

	// ----------------------------------------
	// result formatting and compare
	// ----------------------------------------
	logic left_just;
	logic sgn;
	logic [15:0] result_word;
	logic [15:0] gt_word;
	logic [15:0] lt_word;
	logic cmp_match;
	logic match_event;
	awd_pkg::awd_win_mode_t win_mode;

	assign left_just = cfg_q[`AWD_CFG_LEFT_BIT];
	assign sgn = cfg_q[`AWD_CFG_DIFF_BIT];
	assign result_word = awd_pkg::awd_format(conv.data, left_just, sgn); // [RULE6] [RULE9]
	assign gt_word = {gt_hi_q, gt_lo_q}; // [RULE3]
	assign lt_word = {lt_hi_q, lt_lo_q}; // [RULE3]

	awd_window_cmp u_cmp (
		.word(result_word),
		.gt_limit(gt_word),
		.lt_limit(lt_word),
		.signed_mode(sgn),
		.match(cmp_match),
		.mode(win_mode)
	);

	assign match_event = conv.valid && cmp_match; // [RULE1]

	// ----------------------------------------
	// control register and flags
	// ----------------------------------------
	logic win_clear;
	logic done_clear;
	logic win_flag_d;
	logic done_flag_d;

	assign win_clear = wr_ctrl && !bus.wdata[`AWD_CTRL_WIN_BIT];
	assign done_clear = wr_ctrl && !bus.wdata[`AWD_CTRL_DONE_BIT];
	assign win_flag_d = match_event || (ctrl_q[`AWD_CTRL_WIN_BIT] && !win_clear); // [RULE12]
	assign done_flag_d = conv.valid || (ctrl_q[`AWD_CTRL_DONE_BIT] && !done_clear);

	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d = bus.wdata;
		end
		ctrl_d[`AWD_CTRL_BUSY_BIT] = 1'b0;
		ctrl_d[`AWD_CTRL_WIN_BIT] = win_flag_d;
		ctrl_d[`AWD_CTRL_DONE_BIT] = done_flag_d;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= `AWD_CTRL_RST;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// ----------------------------------------
	// configuration and limits
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_q <= `AWD_CFG_RST;
		end else if (wr_cfg) begin
			cfg_q <= bus.wdata[1:0];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			gt_hi_q <= 8'(`AWD_GT_RST >> 8);
			gt_lo_q <= 8'(`AWD_GT_RST);
		end else begin
			gt_hi_q <= wr_gt_hi ? bus.wdata : gt_hi_q; // [RULE3]
			gt_lo_q <= wr_gt_lo ? bus.wdata : gt_lo_q; // [RULE3]
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lt_hi_q <= 8'(`AWD_LT_RST >> 8);
			lt_lo_q <= 8'(`AWD_LT_RST);
		end else begin
			lt_hi_q <= wr_lt_hi ? bus.wdata : lt_hi_q; // [RULE3]
			lt_lo_q <= wr_lt_lo ? bus.wdata : lt_lo_q; // [RULE3]
		end
	end

	// ----------------------------------------
	// result holding
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			res_q <= 16'h0000;
		end else if (conv.valid) begin
			res_q <= result_word;
		end
	end

	// ----------------------------------------
	// interrupt status and mask
	// ----------------------------------------
	logic [1:0] stat_set;
	logic [1:0] stat_clr;

	assign stat_set = {conv.valid, match_event};
	assign stat_clr = wr_stat ? bus.wdata[1:0] : 2'h0;
	assign stat_d = (stat_q & ~stat_clr) | stat_set;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stat_q <= `AWD_INT_RST;
			mask_q <= `AWD_INT_RST;
		end else begin
			stat_q <= stat_d;
			mask_q <= wr_mask ? bus.wdata[1:0] : mask_q;
		end
	end

	assign irq = |(stat_q & mask_q); // [RULE2]

	// ----------------------------------------
	// read path
	// ----------------------------------------
	logic [7:0] ctrl_view;
	logic [7:0] rd_mux;

	assign ctrl_view = {ctrl_q[7:5], conversion_busy, ctrl_q[3:0]};

	always_comb begin
		case (bus.addr)
			`AWD_CTRL_ADDR: rd_mux = ctrl_view; // [RULE2]
			`AWD_CFG_ADDR: rd_mux = {6'h00, cfg_q};
			`AWD_RES_HI_ADDR: rd_mux = res_q[15:8];
			`AWD_RES_LO_ADDR: rd_mux = res_q[7:0];
			`AWD_GT_HI_ADDR: rd_mux = gt_hi_q;
			`AWD_GT_LO_ADDR: rd_mux = gt_lo_q;
			`AWD_LT_HI_ADDR: rd_mux = lt_hi_q;
			`AWD_LT_LO_ADDR: rd_mux = lt_lo_q;
			`AWD_INT_STAT_ADDR: rd_mux = {6'h00, stat_q};
			`AWD_INT_MASK_ADDR: rd_mux = {6'h00, mask_q};
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data_q <= 8'h00;
		end else begin
			rd_data_q <= bus.rd ? rd_mux : 8'h00;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign rd_data = rd_data_q;
	assign converter_enable = ctrl_q[`AWD_CTRL_EN_BIT];
	assign tracking_mode_select = ctrl_q[`AWD_CTRL_TM_BIT];
	assign start_source_select = ctrl_q[`AWD_CTRL_CM_LSB +: 3];
	assign window_match_flag = ctrl_q[`AWD_CTRL_WIN_BIT]; // [RULE2]

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	logic chk_above;
	logic chk_below;
	logic chk_inside_cfg;

	assign chk_above = sgn ? ($signed(result_word) > $signed(gt_word)) : (result_word > gt_word);
	assign chk_below = sgn ? ($signed(result_word) < $signed(lt_word)) : (result_word < lt_word);
	assign chk_inside_cfg = sgn ? ($signed(lt_word) > $signed(gt_word)) : (lt_word > gt_word);

	sequence seq_hit;
		conv.valid && cmp_match;
	endsequence

	sequence seq_flag_idle;
		window_match_flag && !win_clear;
	endsequence

	sequence seq_read_ctrl;
		bus.rd && (bus.addr == `AWD_CTRL_ADDR);
	endsequence

	AST_HIT_SETS_FLAG: assert property ( // [RULE1]
		seq_hit |=> window_match_flag ##0 (stat_q[`AWD_INT_WIN_BIT]))
		else $error("window hit did not raise the flag");

	AST_READ_SHOWS_FLAG: assert property ( // [RULE2]
		seq_read_ctrl |=> (rd_data[`AWD_CTRL_WIN_BIT] == $past(window_match_flag)))
		else $error("control read does not show the flag");

	AST_LIMIT_BYTE_WRITE: assert property ( // [RULE3]
		wr_lt_lo |=> (lt_word[7:0] == $past(bus.wdata)) && $stable(lt_hi_q))
		else $error("less limit low byte not stored");

	AST_UNSIGNED_RESULT: assert property ( // [RULE6]
		(conv.valid && !sgn && !left_just) |-> (result_word[15:10] == 6'h00))
		else $error("single-ended right result not zero extended");

	AST_INSIDE_STRICT: assert property ( // [RULE7]
		(conv.valid && chk_inside_cfg && !(chk_above && chk_below) && !window_match_flag)
		|=> !window_match_flag)
		else $error("inside window flagged a result outside the limits");

	AST_OUTSIDE_HIT: assert property ( // [RULE8]
		(conv.valid && !chk_inside_cfg && (chk_above || chk_below)) |=> window_match_flag)
		else $error("outside window missed a result beyond the limits");

	AST_SIGNED_RESULT: assert property ( // [RULE9]
		(conv.valid && sgn && !left_just) |-> (result_word[15:10] == {6{conv.data[9]}}))
		else $error("differential right result not sign extended");

	AST_SIGNED_LIMITS: assert property ( // [RULE10]
		(conv.valid && sgn && gt_word == 16'hffff && lt_word == 16'h0040
		&& result_word == 16'h0000) |-> (win_mode == awd_pkg::AWD_WIN_INSIDE) ##1 window_match_flag)
		else $error("signed limits not compared as signed");

	AST_MODE_FROM_LIMITS: assert property ( // [RULE11]
		(win_mode == awd_pkg::AWD_WIN_INSIDE) == chk_inside_cfg)
		else $error("window mode does not follow the limit contents");

	AST_FLAG_STICKY: assert property ( // [RULE12]
		seq_flag_idle |=> window_match_flag)
		else $error("flag dropped without a clearing write");

	AST_FLAG_CLEARS: assert property ( // [RULE12]
		(win_clear && !match_event) |=> !window_match_flag ##1 (window_match_flag == $past(match_event)))
		else $error("writing zero did not clear the flag");

endmodule
`default_nettype wire

// >>> pkg/awd_defines.svh
`ifndef AWD_DEFINES_SVH
`define AWD_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define AWD_CTRL_ADDR 8'he8
`define AWD_CFG_ADDR 8'hc0
`define AWD_RES_HI_ADDR 8'hc1
`define AWD_RES_LO_ADDR 8'hc2
`define AWD_GT_HI_ADDR 8'hc3
`define AWD_GT_LO_ADDR 8'hc4
`define AWD_LT_HI_ADDR 8'hc5
`define AWD_LT_LO_ADDR 8'hc6
`define AWD_INT_STAT_ADDR 8'hc7
`define AWD_INT_MASK_ADDR 8'hc8

// ----------------------------------------
// field positions
// ----------------------------------------
`define AWD_CTRL_EN_BIT 7
`define AWD_CTRL_TM_BIT 6
`define AWD_CTRL_DONE_BIT 5
`define AWD_CTRL_BUSY_BIT 4
`define AWD_CTRL_WIN_BIT 3
`define AWD_CTRL_CM_LSB 0
`define AWD_CFG_LEFT_BIT 0
`define AWD_CFG_DIFF_BIT 1
`define AWD_INT_WIN_BIT 0
`define AWD_INT_DONE_BIT 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define AWD_CTRL_RST 8'h00
`define AWD_CFG_RST 2'h0
`define AWD_GT_RST 16'hffff
`define AWD_LT_RST 16'h0000
`define AWD_INT_RST 2'h0

`endif

// >>> pkg/awd_pkg.sv
`default_nettype none
package awd_pkg;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} awd_bus_req_t;

	typedef struct packed {
		logic valid;
		logic [9:0] data;
	} awd_result_t;

	typedef enum logic [1:0] {
		AWD_WIN_INSIDE = 2'b01,
		AWD_WIN_OUTSIDE = 2'b10
	} awd_win_mode_t;

	// ----------------------------------------
	// arithmetic
	// ----------------------------------------
	function automatic logic awd_greater(input logic [15:0] a, input logic [15:0] b,
		input logic sgn);
		awd_greater = sgn ? ($signed(a) > $signed(b)) : (a > b);
	endfunction

	function automatic logic [15:0] awd_format(input logic [9:0] raw, input logic left,
		input logic sgn);
		if (left) begin
			awd_format = {raw, 6'h00};
		end else if (sgn) begin
			awd_format = {{6{raw[9]}}, raw};
		end else begin
			awd_format = {6'h00, raw};
		end
	endfunction

endpackage
`default_nettype wire

// >>> sim/awd_conv_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// converter core stand-in
// ----------------------------------------
module awd_conv_model (
	input wire logic clk,
	input wire logic start,
	input wire logic [9:0] start_data,
	input wire logic [3:0] dly,
	output var awd_pkg::awd_result_t conv,
	output logic busy
);
	// busy for dly+1 cycles, the last with one valid pulse, then idle data shows the inverse
	initial begin
		conv = '{valid: 1'h0, data: 10'h155};
		busy = 1'h0;
		forever begin
			@(posedge clk);
			if (start) begin
				busy <= 1'h1;
				repeat (dly) @(posedge clk);
				conv <= '{valid: 1'h1, data: start_data};
				@(posedge clk);
				conv <= '{valid: 1'h0, data: ~start_data};
				busy <= 1'h0;
			end
		end
	end
endmodule
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "awd_defines.svh"
module tb;
	logic clk;
	logic arst_n;
	awd_pkg::awd_bus_req_t bus;
	logic [7:0] rd_data;
	awd_pkg::awd_result_t conv;
	logic busy;
	logic en;
	logic tm;
	logic wmf;
	logic irq;
	logic [2:0] ss;
	logic start;
	logic [9:0] sdata;
	logic [3:0] dly;
	int failures;
	int total_checks;
	logic [44:0] cs;
	logic [15:0] w;
	// cfg, greater limit, less limit, raw result, expected match
	localparam logic [44:0] case_tab [20] = '{
		{2'h0, 16'h0040, 16'h0080, 10'h041, 1'h1}, {2'h0, 16'h0040, 16'h0080, 10'h040, 1'h0},
		{2'h0, 16'h0040, 16'h0080, 10'h07f, 1'h1}, {2'h0, 16'h0040, 16'h0080, 10'h080, 1'h0},
		{2'h0, 16'h0080, 16'h0040, 10'h03f, 1'h1}, {2'h0, 16'h0080, 16'h0040, 10'h040, 1'h0},
		{2'h0, 16'h0080, 16'h0040, 10'h081, 1'h1}, {2'h0, 16'h0080, 16'h0040, 10'h060, 1'h0},
		{2'h0, 16'h0040, 16'h0040, 10'h041, 1'h1}, {2'h0, 16'h0000, 16'h03ff, 10'h3fe, 1'h1},
		{2'h0, 16'h0000, 16'h03ff, 10'h3ff, 1'h0}, {2'h1, 16'h1000, 16'h2000, 10'h041, 1'h1},
		{2'h1, 16'h1000, 16'h2000, 10'h040, 1'h0}, {2'h2, 16'hffff, 16'h0040, 10'h000, 1'h1},
		{2'h2, 16'hffff, 16'h0040, 10'h3ff, 1'h0}, {2'h2, 16'hffff, 16'h0040, 10'h03f, 1'h1},
		{2'h2, 16'h0040, 16'hffff, 10'h3fe, 1'h1}, {2'h2, 16'h0040, 16'hffff, 10'h000, 1'h0},
		{2'h3, 16'hffc0, 16'h1000, 10'h000, 1'h1}, {2'h3, 16'hffc0, 16'h1000, 10'h3ff, 1'h0}
	};

	awd_window_detector i_dut (
		.clk(clk),
		.arst_n(arst_n),
		.bus(bus),
		.rd_data(rd_data),
		.conv(conv),
		.conversion_busy(busy),
		.converter_enable(en),
		.tracking_mode_select(tm),
		.start_source_select(ss),
		.window_match_flag(wmf),
		.irq(irq)
	);

	awd_conv_model i_conv (
		.clk(clk),
		.start(start),
		.start_data(sdata),
		.dly(dly),
		.conv(conv),
		.busy(busy)
	);

	initial clk = 1'h0;
	always #50 clk = ~clk;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] fmt16(input logic [1:0] c, input logic [9:0] r);
		if (c[0]) return {r, 6'h00};
		if (c[1]) return {{6{r[9]}}, r};
		return {6'h00, r};
	endfunction

	task close_out;
		if (failures == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
		@(posedge clk);
		bus.wr <= 1'h0;
		#1;
	endtask

	task rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
		@(posedge clk);
		bus.rd <= 1'h0;
		#1;
		chk({8'h00, rd_data}, {8'h00, exp});
	endtask

	task kick(input logic [9:0] r, input logic [3:0] d);
		@(posedge clk);
		start <= 1'h1;
		sdata <= r;
		dly <= d;
		@(posedge clk);
		start <= 1'h0;
	endtask

	task await_result;
		for (int n = 0; n < 20; n++) begin
			@(posedge clk);
			if (conv.valid === 1'h1) begin
				#1;
				return;
			end
		end
		failures++;
		$display("[ERR] %0t no result", $time);
		close_out;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		$display("[ERR] %0t watchdog", $time);
		close_out;
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		arst_n = 1'h0;
		bus = '0;
		start = 1'h0;
		sdata = 10'h000;
		dly = 4'h0;
		failures = 0;
		total_checks = 0;
		repeat (20) @(posedge clk);
		chk({1'h0, irq, wmf, rd_data, en, tm, ss}, 16'h0000);
		arst_n <= 1'h1;
		rd_chk(`AWD_CTRL_ADDR, 8'h00);
		rd_chk(`AWD_GT_HI_ADDR, 8'hff);
		rd_chk(`AWD_GT_LO_ADDR, 8'hff);
		rd_chk(`AWD_LT_HI_ADDR, 8'h00);
		rd_chk(`AWD_LT_LO_ADDR, 8'h00);
		rd_chk(`AWD_INT_STAT_ADDR, 8'h00);
		rd_chk(`AWD_INT_MASK_ADDR, 8'h00);
		wr(8'h10, 8'hff);
		rd_chk(8'h10, 8'h00);
		wr(`AWD_CTRL_ADDR, 8'hd5);
		chk({11'h000, en, tm, ss}, 16'h001d);
		kick(10'h155, 4'h6);
		rd_chk(`AWD_CTRL_ADDR, 8'hd5);
		await_result;
		rd_chk(`AWD_CTRL_ADDR, 8'he5);
		for (int i = 0; i < 20; i++) begin
			cs = case_tab[i];
			w = fmt16(cs[44:43], cs[10:1]);
			wr(`AWD_CFG_ADDR, {6'h00, cs[44:43]});
			rd_chk(`AWD_CFG_ADDR, {6'h00, cs[44:43]});
			wr(`AWD_GT_HI_ADDR, cs[42:35]);
			wr(`AWD_GT_LO_ADDR, cs[34:27]);
			wr(`AWD_LT_HI_ADDR, cs[26:19]);
			wr(`AWD_LT_LO_ADDR, cs[18:11]);
			wr(`AWD_CTRL_ADDR, 8'h80);
			wr(`AWD_INT_STAT_ADDR, 8'h03);
			kick(cs[10:1], 4'(i % 3));
			await_result;
			chk({15'h0000, wmf}, {15'h0000, cs[0]});
			rd_chk(`AWD_CTRL_ADDR, {4'ha, cs[0], 3'h0});
			rd_chk(`AWD_INT_STAT_ADDR, {7'h00, cs[0]} | 8'h02);
			rd_chk(`AWD_RES_HI_ADDR, w[15:8]);
			rd_chk(`AWD_RES_LO_ADDR, w[7:0]);
			chk({15'h0000, irq}, 16'h0000);
		end
		wr(`AWD_CTRL_ADDR, 8'h80);
		wr(`AWD_INT_STAT_ADDR, 8'h03);
		kick(10'h000, 4'h1);
		await_result;
		chk({14'h0000, wmf, irq}, 16'h0002);
		wr(`AWD_INT_MASK_ADDR, 8'h01);
		chk({15'h0000, irq}, 16'h0001);
		kick(10'h3ff, 4'h0);
		await_result;
		chk({15'h0000, wmf}, 16'h0001);
		rd_chk(`AWD_INT_STAT_ADDR, 8'h03);
		wr(`AWD_CTRL_ADDR, 8'ha8);
		chk({15'h0000, wmf}, 16'h0001);
		wr(`AWD_INT_STAT_ADDR, 8'h01);
		chk({14'h0000, wmf, irq}, 16'h0002);
		rd_chk(`AWD_INT_STAT_ADDR, 8'h02);
		wr(`AWD_INT_MASK_ADDR, 8'h02);
		chk({15'h0000, irq}, 16'h0001);
		wr(`AWD_INT_STAT_ADDR, 8'h02);
		chk({15'h0000, irq}, 16'h0000);
		wr(`AWD_CTRL_ADDR, 8'h80);
		chk({15'h0000, wmf}, 16'h0000);
		rd_chk(`AWD_CTRL_ADDR, 8'h80);
		close_out;
	end
endmodule
`default_nettype wire
